// ### rtl/apctl_pkg.sv
// Function
// - Select register clears to zero on reset
// - Select low bits pick one of four accumulators
// - Unused select and control bits read zero
// - Control register clears on reset, stepping off
// - Modulo field: off, 2, 4, reserved as 4
// - Step selection after each operation when enabled
// - Direction bit six: zero increments, one decrements
// - Clear bit seven zeroes selection, then self-clears
// - Clear via control write beats same-cycle step
// - Register addressed by index and module specifier
package apctl_pkg;

   // Register addressing on the special-purpose register port
   localparam logic [4:0] APCTL_MODULE_SPEC = 5'h08;
   localparam logic [4:0] APCTL_IDX_SELECT  = 5'h00;
   localparam logic [4:0] APCTL_IDX_CONTROL = 5'h01;

   // Reset values
   localparam logic [7:0] APCTL_SELECT_RESET  = 8'h00;
   localparam logic [7:0] APCTL_CONTROL_RESET = 8'h00;

   // Control register field positions
   localparam int APCTL_CLEAR_BIT = 7;
   localparam int APCTL_DIR_BIT   = 6;
   localparam int APCTL_MOD_LSB   = 0;

   // Wrap modulo codes
   localparam logic [1:0] APCTL_MOD_OFF  = 2'h0;
   localparam logic [1:0] APCTL_MOD_TWO  = 2'h1;
   localparam logic [1:0] APCTL_MOD_FOUR = 2'h2;
   localparam logic [1:0] APCTL_MOD_RSVD = 2'h3;

   // Value returned for unmapped reads
   localparam logic [7:0] APCTL_UNMAPPED_DATA = 8'h00;

endpackage

// ### rtl/apctl_step.sv
`timescale 1ns/1ps
module apctl_step
   import apctl_pkg::*;
(
   input  wire logic [1:0] ptr,
   input  wire logic [1:0] wrap_modulo_select,
   input  wire logic       step_direction_select,
   output logic      [1:0] next_ptr
);

   // Next pointer within the chosen modulo
   function automatic logic [1:0] step_ptr(input logic [1:0] p,
                                           input logic [1:0] m,
                                           input logic       dn);
      logic [1:0] r;
      r = p;
      case (m)
         APCTL_MOD_OFF:
            r = p;
         APCTL_MOD_TWO:
            r = {p[1], ~p[0]};
         APCTL_MOD_FOUR, APCTL_MOD_RSVD:
            // Reserved code behaves as modulo 4; 2-bit wrap is free
            r = dn ? p - 2'h1 : p + 2'h1;
         default:
            r = p;
      endcase
      return r;
   endfunction

   always_comb
   begin
      next_ptr = step_ptr(ptr, wrap_modulo_select, step_direction_select);
   end

endmodule

// ### rtl/apctl_top.sv
`timescale 1ns/1ps
module apctl_top
   import apctl_pkg::*;
(
   input  wire logic       SYS_CLK,
   input  wire logic       RESET_N,
   input  wire logic       CLK_EN,
   input  wire logic [4:0] SPR_INDEX,
   input  wire logic [4:0] SPR_MODULE,
   input  wire logic       SPR_WR,
   input  wire logic       SPR_RD,
   input  wire logic [7:0] SPR_WDATA,
   input  wire logic       OP_DONE,
   output logic      [7:0] SPR_RDATA,
   output logic      [1:0] ACTIVE_ACC
);
   import apctl_pkg::*;

   typedef struct packed {
      logic [1:0] active_acc_select;
      logic [1:0] wrap_modulo_select;
      logic       step_direction_select;
      logic       pointer_clear;
      logic [7:0] rdata;
   } apctl_state_t;

   apctl_state_t st;
   apctl_state_t next_st;
   logic         mod_hit;
   logic         wr_select;
   logic         wr_control;
   logic         clear_req;
   logic         step_en;
   logic [1:0]   stepped;

   // Both registers live under one module specifier
   always_comb
   begin
      mod_hit    = (SPR_MODULE == APCTL_MODULE_SPEC);
      wr_select  = SPR_WR && mod_hit && (SPR_INDEX == APCTL_IDX_SELECT);
      wr_control = SPR_WR && mod_hit && (SPR_INDEX == APCTL_IDX_CONTROL);
      clear_req  = wr_control && SPR_WDATA[APCTL_CLEAR_BIT];
      step_en    = OP_DONE && (st.wrap_modulo_select != APCTL_MOD_OFF);
   end

   apctl_step u_step (
      .ptr                   (st.active_acc_select),
      .wrap_modulo_select    (st.wrap_modulo_select),
      .step_direction_select (st.step_direction_select),
      .next_ptr              (stepped)
   );

   // Next state: clear beats software write beats auto step
   always_comb
   begin
      next_st = st;
      // Clear bit shows for one cycle only, then drops by itself
      next_st.pointer_clear = clear_req;
      if (wr_control)
      begin
         next_st.wrap_modulo_select    = SPR_WDATA[APCTL_MOD_LSB +: 2];
         next_st.step_direction_select = SPR_WDATA[APCTL_DIR_BIT];
      end
      if (clear_req)
         next_st.active_acc_select = 2'h0;
      else if (wr_select)
         next_st.active_acc_select = SPR_WDATA[1:0];
      else if (step_en)
         next_st.active_acc_select = stepped;
      // Read data is registered so the output comes from a flop
      if (SPR_RD)
      begin
         if (mod_hit && SPR_INDEX == APCTL_IDX_SELECT)
            next_st.rdata = {6'h00, st.active_acc_select};
         else if (mod_hit && SPR_INDEX == APCTL_IDX_CONTROL)
            next_st.rdata = {st.pointer_clear,
                             st.step_direction_select,
                             4'h0, st.wrap_modulo_select};
         else
            next_st.rdata = APCTL_UNMAPPED_DATA;
      end
   end

   // Single register bank; enable low freezes everything except the synchronous reset, which is not gated by the enable
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         st.active_acc_select     <= APCTL_SELECT_RESET[1:0];
         st.wrap_modulo_select    <= APCTL_CONTROL_RESET[1:0];
         st.step_direction_select <= APCTL_CONTROL_RESET[6];
         st.pointer_clear         <= APCTL_CONTROL_RESET[7];
         st.rdata                 <= APCTL_UNMAPPED_DATA;
      end
      else if (CLK_EN)
         st <= next_st;
   end

   assign SPR_RDATA  = st.rdata;
   assign ACTIVE_ACC = st.active_acc_select;

   // Helper terms for checks
   logic quiet_op;
   logic rd_select;
   logic rd_control;
   assign quiet_op   = CLK_EN && OP_DONE && !wr_select && !wr_control;
   assign rd_select  = CLK_EN && SPR_RD && mod_hit
                       && (SPR_INDEX == APCTL_IDX_SELECT);
   assign rd_control = CLK_EN && SPR_RD && mod_hit
                       && (SPR_INDEX == APCTL_IDX_CONTROL);

   property p_reset_select;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      $rose(RESET_N) |-> ACTIVE_ACC == 2'h0 && SPR_RDATA == 8'h00;
   endproperty
   a_reset_select: assert property (p_reset_select)
      else $error("select not zero after reset");

   property p_reset_control;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      $rose(RESET_N) |-> st.wrap_modulo_select == APCTL_MOD_OFF
                         && !st.step_direction_select && !st.pointer_clear;
   endproperty
   a_reset_control: assert property (p_reset_control)
      else $error("control not zero after reset");

   property p_write_select;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      CLK_EN && wr_select && !wr_control
         |=> ACTIVE_ACC == $past(SPR_WDATA[1:0]);
   endproperty
   a_write_select: assert property (p_write_select)
      else $error("select write not applied");

   property p_reserved_zero;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (rd_select |=> SPR_RDATA[7:2] == 6'h00)
      and (rd_control |=> SPR_RDATA[5:2] == 4'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read nonzero");

   property p_no_step_off;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      quiet_op && st.wrap_modulo_select == APCTL_MOD_OFF
         |=> $stable(ACTIVE_ACC);
   endproperty
   a_no_step_off: assert property (p_no_step_off)
      else $error("selection moved with stepping off");

   property p_mod_two;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      quiet_op && st.wrap_modulo_select == APCTL_MOD_TWO
         |=> ACTIVE_ACC[1] == $past(ACTIVE_ACC[1])
             && ACTIVE_ACC[0] != $past(ACTIVE_ACC[0]);
   endproperty
   a_mod_two: assert property (p_mod_two)
      else $error("modulo 2 step wrong");

   property p_mod_four;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      quiet_op && st.wrap_modulo_select[1]
         |=> ACTIVE_ACC == ($past(st.step_direction_select)
                            ? 2'($past(ACTIVE_ACC) - 2'h1)
                            : 2'($past(ACTIVE_ACC) + 2'h1));
   endproperty
   a_mod_four: assert property (p_mod_four)
      else $error("modulo 4 step wrong");

   sequence s_cleared;
      ACTIVE_ACC == 2'h0 && st.pointer_clear;
   endsequence

   sequence s_clear_dropped;
      !st.pointer_clear;
   endsequence

   property p_clear_self;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      CLK_EN && clear_req ##1 CLK_EN && !clear_req
         |-> s_cleared ##1 s_clear_dropped;
   endproperty
   a_clear_self: assert property (p_clear_self)
      else $error("clear did not zero or self-clear");

   property p_clear_wins;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      CLK_EN && clear_req && OP_DONE |=> ACTIVE_ACC == 2'h0;
   endproperty
   a_clear_wins: assert property (p_clear_wins)
      else $error("step overrode clear");

   property p_unmapped;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      CLK_EN && SPR_RD && !mod_hit |=> SPR_RDATA == APCTL_UNMAPPED_DATA;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("wrong module answered");

   // Any enabled mode must actually move the selection
   property p_step_taken;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      quiet_op && st.wrap_modulo_select != APCTL_MOD_OFF
         |=> ACTIVE_ACC != $past(ACTIVE_ACC);
   endproperty
   a_step_taken: assert property (p_step_taken)
      else $error("selection did not step");

   // Control fields land one cycle after the write
   property p_write_control;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      CLK_EN && wr_control
         |=> st.wrap_modulo_select == $past(SPR_WDATA[1:0])
             && st.step_direction_select == $past(SPR_WDATA[APCTL_DIR_BIT]);
   endproperty
   a_write_control: assert property (p_write_control)
      else $error("control write not applied");

   // Select readback shows the selection before the edge
   property p_read_select;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      rd_select |=> SPR_RDATA[1:0] == $past(ACTIVE_ACC);
   endproperty
   a_read_select: assert property (p_read_select)
      else $error("select readback wrong");

   // Clear bit is visible for the one cycle it stands
   property p_read_clear;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      rd_control |=> SPR_RDATA[7] == $past(st.pointer_clear);
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("clear bit readback wrong");

endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) check_eq(8'(g), 8'(e))
module testbench;
   import apctl_pkg::*;
   logic       sys_clk     = 1'b0;
   logic       reset_n     = 1'b0;
   logic       clk_en      = 1'b1;
   logic [4:0] spr_index   = 5'h00;
   logic [4:0] spr_module  = 5'h08;
   logic       spr_wr      = 1'b0;
   logic       spr_rd      = 1'b0;
   logic [7:0] spr_wdata   = 8'h00;
   logic       op_done     = 1'b0;
   logic [7:0] spr_rdata;
   logic [1:0] active_acc;
   int         compares    = 0;
   int         miscompares = 0;
   int         seed        = 31570;
   bit         chk_on      = 1'b0;
   bit         prev_clr    = 1'b0;
   logic [1:0] m_sel;
   logic [1:0] m_mod;
   logic       m_dir;
   logic       m_clr;
   logic [7:0] m_rdata;
   logic       hit;
   logic       ws;
   logic       wc;

   apctl_top u_apctl_top (.SYS_CLK(sys_clk), .RESET_N(reset_n),
      .CLK_EN(clk_en), .SPR_INDEX(spr_index), .SPR_MODULE(spr_module),
      .SPR_WR(spr_wr), .SPR_RD(spr_rd), .SPR_WDATA(spr_wdata),
      .OP_DONE(op_done), .SPR_RDATA(spr_rdata), .ACTIVE_ACC(active_acc));

   always #12.5 sys_clk = ~sys_clk;

   // Expected step; modulo 2 ignores direction since a toggle is symmetric
   function automatic logic [1:0] f_step(logic [1:0] p, logic [1:0] m,
                                         logic d);
      if (m == APCTL_MOD_OFF)
         return p;
      if (m == APCTL_MOD_TWO)
         return {p[1], ~p[0]};
      return d ? p - 2'h1 : p + 2'h1;
   endfunction

   task automatic check_eq(logic [7:0] g, logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Reference model, priority clear over write over step
   always @(posedge sys_clk)
   begin
      hit = spr_module == APCTL_MODULE_SPEC;
      ws  = spr_wr && hit && spr_index == APCTL_IDX_SELECT;
      wc  = spr_wr && hit && spr_index == APCTL_IDX_CONTROL;
      if (!reset_n)
      begin
         {m_sel, m_mod, m_dir, m_clr, m_rdata} = '0;
      end
      else if (clk_en)
      begin
         if (spr_rd)
            m_rdata = !hit ? APCTL_UNMAPPED_DATA :
               spr_index == APCTL_IDX_SELECT ? {6'h00, m_sel} :
               spr_index == APCTL_IDX_CONTROL ?
               {m_clr, m_dir, 4'h0, m_mod} : APCTL_UNMAPPED_DATA;
         if (wc && spr_wdata[7])
            m_sel = 2'h0;
         else if (ws)
            m_sel = spr_wdata[1:0];
         else if (op_done)
            m_sel = f_step(m_sel, m_mod, m_dir);
         m_clr = wc && spr_wdata[7];
         if (wc)
            {m_dir, m_mod} = {spr_wdata[6], spr_wdata[1:0]};
      end
   end

   // Outputs compared every cycle once the model is primed
   always @(negedge sys_clk)
   begin
      if (chk_on)
      begin
         `CHK(active_acc, m_sel);
         `CHK(active_acc[1], m_sel[1]);
         `CHK(spr_rdata, m_rdata);
      end
   end

   // One cycle; the cycle after a clear avoids ops, whose outcome is open
   task automatic cyc(bit wr, bit rd, logic [4:0] idx, logic [7:0] wd,
                      bit op);
      spr_wr    = wr && !(prev_clr && idx == 5'h00);
      spr_rd    = rd;
      spr_index = idx;
      spr_wdata = wd;
      op_done   = op && !prev_clr;
      prev_clr  = spr_wr && idx == 5'h01 && wd[7];
      @(negedge sys_clk);
   endtask

   task automatic report_and_stop();
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(negedge sys_clk);
      chk_on = 1'b1;
      repeat (14) @(negedge sys_clk);
      reset_n = 1'b1;
      cyc(0, 1, 5'h00, 8'h00, 0);
      cyc(0, 1, 5'h01, 8'h00, 0);
      // Every modulo code and direction with back-to-back operations
      for (int m = 0; m < 4; m++)
         for (int d = 0; d < 2; d++)
         begin
            cyc(1, 0, 5'h01, 8'(d * 64 + m), 0);
            cyc(1, 0, 5'h00, 8'h03, 1);
            repeat (5) cyc(0, 1, 5'h00, 8'h00, 1);
         end
      // Clear together with an operation, reserved bits, readback
      cyc(1, 0, 5'h00, 8'hff, 0);
      cyc(1, 1, 5'h01, 8'hff, 1);
      cyc(0, 1, 5'h01, 8'h00, 0);
      cyc(0, 1, 5'h01, 8'h00, 0);
      // Reset in mid-run with non-zero state
      cyc(1, 0, 5'h00, 8'h02, 0);
      reset_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      reset_n = 1'b1;
      cyc(0, 1, 5'h01, 8'h00, 0);
      for (int i = 0; i < 4000; i++)
      begin
         clk_en     = ($random(seed) & 7) != 0;
         spr_module = (($random(seed) & 7) == 0) ? 5'($random(seed))
                                                 : APCTL_MODULE_SPEC;
         cyc($random(seed), $random(seed), 5'($random(seed) & 3),
             8'($random(seed)), $random(seed));
      end
      report_and_stop();
   end
endmodule
